/* File: hdl/tp_pkg.sv */
// constants and types for the link test pattern controller
package tp_pkg;

  // register addresses
  localparam logic [11:0] ADDR_MODE_B    = 12'h572;
  localparam logic [11:0] ADDR_MODE_C    = 12'h573;
  localparam logic [11:0] ADDR_MODE_D    = 12'h574;
  localparam logic [11:0] ADDR_PHASE     = 12'h578;
  localparam logic [11:0] ADDR_DEVID     = 12'h580;
  localparam logic [11:0] ADDR_USER_BASE = 12'h5a0;
  localparam logic [11:0] ADDR_STATUS    = 12'h5a8;
  localparam int          USER_BYTES     = 8;

  // reset values and writable bit masks
  localparam logic [7:0] RST_MODE_B  = 8'h00;
  localparam logic [7:0] RST_MODE_C  = 8'h00;
  localparam logic [7:0] RST_MODE_D  = 8'h00;
  localparam logic [7:0] RST_PHASE   = 8'h00;
  localparam logic [7:0] RST_DEVID   = 8'h00;
  localparam logic [7:0] RST_USER    = 8'h00;
  localparam logic [7:0] MASK_MODE_B = 8'hf6;
  localparam logic [7:0] MASK_MODE_C = 8'hff;
  localparam logic [7:0] MASK_MODE_D = 8'hf7;
  localparam logic [7:0] MASK_PHASE  = 8'h1f;

  // field positions
  localparam int TP_LSB  = 0;
  localparam int LT_LSB  = 0;
  localparam int ST_DONE = 0;
  localparam int ST_EMPTY = 1;
  localparam int ST_FULL = 2;

  // transport test selector codes
  localparam logic [3:0] TP_OFF      = 4'h0;
  localparam logic [3:0] TP_CHECKER  = 4'h1;
  localparam logic [3:0] TP_TOGGLE   = 4'h2;
  localparam logic [3:0] TP_PN31     = 4'h3;
  localparam logic [3:0] TP_PN23     = 4'h4;
  localparam logic [3:0] TP_PN15     = 4'h5;
  localparam logic [3:0] TP_PN9      = 4'h6;
  localparam logic [3:0] TP_PN7      = 4'h7;
  localparam logic [3:0] TP_RAMP     = 4'h8;
  localparam logic [3:0] TP_USER_REP = 4'he;
  localparam logic [3:0] TP_USER_ONE = 4'hf;

  // link-layer test selector codes
  localparam logic [2:0] LT_OFF    = 3'h0;
  localparam logic [2:0] LT_D21_5  = 3'h1;
  localparam logic [2:0] LT_RPAT   = 3'h4;
  localparam logic [2:0] LT_JSPAT  = 3'h5;
  localparam logic [2:0] LT_JTSPAT = 3'h6;

  // pattern octets and sequences
  localparam logic [7:0]  CHECK_A   = 8'haa;
  localparam logic [7:0]  CHECK_B   = 8'h55;
  localparam logic [7:0]  D21_5     = 8'hb5;
  localparam logic [30:0] PN_SEED   = 31'h7fffffff;
  localparam int          SEQ_LEN   = 12;
  localparam logic [7:0] RPAT_SEQ [SEQ_LEN] = '{
    8'hbe, 8'hd7, 8'h23, 8'h47, 8'h6b, 8'h8f,
    8'hb3, 8'h14, 8'h5e, 8'hfb, 8'h35, 8'h59};
  localparam logic [7:0] JSPAT_SEQ [SEQ_LEN] = '{
    8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06,
    8'h07, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c};
  localparam logic [7:0] JTSPAT_SEQ [SEQ_LEN] = '{
    8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16,
    8'h17, 8'h18, 8'h19, 8'h1a, 8'h1b, 8'h1c};

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [11:0] addr;
    logic [7:0]  wdata;
  } reg_req_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } reg_rsp_t;

  typedef enum logic [1:0] {USER_IDLE, USER_RUN, USER_DONE} user_state_t;

endpackage

/* File: hdl/sample_fifo.sv */
// synchronous fifo for converter sample words
`timescale 1ns/100ps
module sample_fifo #(
  parameter int W     = 16,
  parameter int DEPTH = 32
) (
  input  wire logic         i_sys_clk,
  input  wire logic         i_resetn,
  input  wire logic         i_in_valid,
  input  wire logic [W-1:0] i_in_data,
  output logic              o_in_ready,
  output logic              o_out_valid,
  output logic [W-1:0]      o_out_data,
  input  wire logic         i_out_ready
);
  localparam int AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
      $error("sample_fifo: depth must be a power of two");
  end

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0]   count;
  logic          push;
  logic          pop;

  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;
  assign o_out_data  = mem[rd_ptr];
  assign o_out_valid = (count != '0);

  always_ff @(posedge i_sys_clk) begin
    if (push) begin
      mem[wr_ptr] <= i_in_data;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wr_ptr     <= '0;
      rd_ptr     <= '0;
      count      <= '0;
      o_in_ready <= 1'b1;
    end else begin
      if (push) wr_ptr <= wr_ptr + 1'b1;
      if (pop) rd_ptr <= rd_ptr + 1'b1;
      if (push && !pop) begin
        count      <= count + 1'b1;
        o_in_ready <= (count != (AW + 1)'(DEPTH - 1));
      end else if (pop && !push) begin
        count      <= count - 1'b1;
        o_in_ready <= 1'b1;
      end
    end
  end
endmodule

/* File: hdl/pn_seq_gen.sv */
// selectable pseudo-random word generator
`timescale 1ns/100ps
module pn_seq_gen #(
  parameter int W = 16
) (
  input  wire logic         i_sys_clk,
  input  wire logic         i_resetn,
  input  wire logic         i_restart,
  input  wire logic         i_adv,
  input  wire logic [3:0]   i_mode,
  output logic [W-1:0]      o_word
);
  logic [30:0] state;
  logic [30:0] next_state;

  // o_word is the next w bits the sequence will produce
  always_comb begin
    int   order;
    int   tap;
    logic fb;
    order = 31;
    tap   = 28;
    fb    = 1'b0;
    case (i_mode)
      tp_pkg::TP_PN23: begin order = 23; tap = 18; end
      tp_pkg::TP_PN15: begin order = 15; tap = 14; end
      tp_pkg::TP_PN9:  begin order = 9;  tap = 5;  end
      tp_pkg::TP_PN7:  begin order = 7;  tap = 6;  end
      default:         begin order = 31; tap = 28; end
    endcase
    next_state = state;
    o_word     = '0;
    for (int i = 0; i < W; i++) begin
      fb            = next_state[order-1] ^ next_state[tap-1];
      o_word[W-1-i] = fb;
      next_state    = {next_state[29:0], fb};
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state <= tp_pkg::PN_SEED;
    end else if (i_restart) begin
      state <= tp_pkg::PN_SEED;
    end else if (i_adv) begin
      state <= next_state;
    end
  end
endmodule

/* File: hdl/jesd_link_test_pattern_ctrl.sv */
// test pattern and link test sequence control for the serial link
// Overview of operation
// RQ1: selector 0000 passes normal converter samples
// RQ2: selector 0001 sends alternating checkerboard words
// RQ3: selector 0010 toggles all ones and zeros
// RQ4: offer pn31 and pn23 sequences
// RQ5: offer pn15 sequence
// RQ6: offer pn9 and pn7 sequences
// RQ7: selector 1000 sends incrementing ramp
// RQ8: 1110 repeats user pattern, 1111 once
// RQ9: link selector 000 sends normal data
// RQ10: link selector 001 sends D21.5 stream
// RQ11: 100/101/110 send RPAT, JSPAT, JTSPAT
// RQ12: receiver checks patterns against local reference; this module has no receive path, only the bench compares link words
`timescale 1ns/100ps
module jesd_link_test_pattern_ctrl #(
  parameter int W     = 16,
  parameter int DEPTH = 32
) (
  input  wire logic             i_sys_clk,
  input  wire logic             i_resetn,
  input  wire tp_pkg::reg_req_t i_reg_req,
  output tp_pkg::reg_rsp_t      o_reg_rsp,
  input  wire logic             i_smp_valid,
  input  wire logic [W-1:0]     i_smp_data,
  output logic                  o_smp_ready,
  output logic                  o_link_valid,
  output logic [W-1:0]          o_link_data,
  input  wire logic             i_link_ready
);
  localparam int OCTETS     = W / 8;
  localparam int USER_WORDS = tp_pkg::USER_BYTES / OCTETS;

  initial begin
    if (W % 8 != 0 || W < 8)
      $error("word width must be a whole number of octets");
    if (tp_pkg::SEQ_LEN % OCTETS != 0)
      $error("word width must divide the link sequence length");
    if (tp_pkg::USER_BYTES % OCTETS != 0)
      $error("word width must divide the user pattern length");
  end

  // registers
  logic [7:0]  mode_b;
  logic [7:0]  mode_c;
  logic [7:0]  mode_d;
  logic [7:0]  phase;
  logic [7:0]  devid;
  logic [7:0]  user_pat [tp_pkg::USER_BYTES];

  logic [3:0]  tp_sel;
  logic [2:0]  lt_sel;
  logic        tp_restart;
  logic        lt_restart;

  // pattern state
  logic        checker_ph;
  logic        toggle_ph;
  logic [W-1:0] ramp;
  logic [$clog2(USER_WORDS+1)-1:0] user_idx;
  logic [$clog2(tp_pkg::SEQ_LEN+1)-1:0] seq_idx;
  tp_pkg::user_state_t user_state;
  tp_pkg::user_state_t next_user_state;

  // datapath
  logic         fifo_valid;
  logic [W-1:0] fifo_data;
  logic         fifo_full_n;
  logic         take;
  logic         is_pn;
  logic [W-1:0] pn_word;
  logic [W-1:0] tp_word;
  logic [W-1:0] next_link_data;

  function automatic logic [W-1:0] rep_octet(input logic [7:0] b);
    logic [W-1:0] r;
    r = '0;
    for (int k = 0; k < OCTETS; k++) begin
      r[k*8 +: 8] = b;
    end
    return r;
  endfunction

  // first octet of a word goes out in the top byte
  function automatic logic [W-1:0] seq_word(input logic [2:0] sel,
                                            input int start);
    logic [W-1:0] r;
    logic [7:0]   b;
    int           j;
    r = '0;
    b = '0;
    j = 0;
    for (int k = 0; k < OCTETS; k++) begin
      j = (start + k) % tp_pkg::SEQ_LEN;
      case (sel)
        tp_pkg::LT_RPAT:  b = tp_pkg::RPAT_SEQ[j];
        tp_pkg::LT_JSPAT: b = tp_pkg::JSPAT_SEQ[j];
        default:          b = tp_pkg::JTSPAT_SEQ[j];
      endcase
      r[(OCTETS-1-k)*8 +: 8] = b;
    end
    return r;
  endfunction

  function automatic logic [W-1:0] user_word(input int widx);
    logic [W-1:0] r;
    r = '0;
    for (int k = 0; k < OCTETS; k++) begin
      r[(OCTETS-1-k)*8 +: 8] = user_pat[widx*OCTETS + k];
    end
    return r;
  endfunction

  assign tp_sel     = mode_c[tp_pkg::TP_LSB +: 4];
  assign lt_sel     = mode_d[tp_pkg::LT_LSB +: 3];
  assign tp_restart = i_reg_req.wr && (i_reg_req.addr == tp_pkg::ADDR_MODE_C);
  assign lt_restart = i_reg_req.wr && (i_reg_req.addr == tp_pkg::ADDR_MODE_D);
  assign is_pn      = (tp_sel >= tp_pkg::TP_PN31) &&
                      (tp_sel <= tp_pkg::TP_PN7);
  assign o_smp_ready = fifo_full_n;
  // a slot opens whenever a sample word is waiting and the link can take it
  assign take = fifo_valid && (!o_link_valid || i_link_ready);

  sample_fifo #(
    .W     (W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .i_sys_clk   (i_sys_clk),
    .i_resetn    (i_resetn),
    .i_in_valid  (i_smp_valid),
    .i_in_data   (i_smp_data),
    .o_in_ready  (fifo_full_n),
    .o_out_valid (fifo_valid),
    .o_out_data  (fifo_data),
    .i_out_ready (take)
  );

  pn_seq_gen #(
    .W (W)
  ) u_pn (
    .i_sys_clk (i_sys_clk),
    .i_resetn  (i_resetn),
    .i_restart (tp_restart),
    .i_adv     (take && is_pn),
    .i_mode    (tp_sel),
    .o_word    (pn_word)
  );

  // register writes
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      mode_b <= tp_pkg::RST_MODE_B;
      mode_c <= tp_pkg::RST_MODE_C;
      mode_d <= tp_pkg::RST_MODE_D;
      phase  <= tp_pkg::RST_PHASE;
      devid  <= tp_pkg::RST_DEVID;
    end else if (i_reg_req.wr) begin
      if (i_reg_req.addr == tp_pkg::ADDR_MODE_B) begin
        mode_b <= i_reg_req.wdata & tp_pkg::MASK_MODE_B;
      end else if (i_reg_req.addr == tp_pkg::ADDR_MODE_C) begin
        mode_c <= i_reg_req.wdata & tp_pkg::MASK_MODE_C;
      end else if (i_reg_req.addr == tp_pkg::ADDR_MODE_D) begin
        mode_d <= i_reg_req.wdata & tp_pkg::MASK_MODE_D;
      end else if (i_reg_req.addr == tp_pkg::ADDR_PHASE) begin
        phase <= i_reg_req.wdata & tp_pkg::MASK_PHASE;
      end else if (i_reg_req.addr == tp_pkg::ADDR_DEVID) begin
        devid <= i_reg_req.wdata;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      for (int i = 0; i < tp_pkg::USER_BYTES; i++) begin
        user_pat[i] <= tp_pkg::RST_USER;
      end
    end else if (i_reg_req.wr &&
                 i_reg_req.addr >= tp_pkg::ADDR_USER_BASE &&
                 i_reg_req.addr < tp_pkg::ADDR_STATUS) begin
      user_pat[3'(i_reg_req.addr - tp_pkg::ADDR_USER_BASE)] <=
        i_reg_req.wdata;
    end
  end

  // register reads
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_reg_rsp <= '0;
    end else begin
      o_reg_rsp.valid <= i_reg_req.rd;
      if (!i_reg_req.rd) begin
        o_reg_rsp.data <= 8'h00;
      end else if (i_reg_req.addr == tp_pkg::ADDR_MODE_B) begin
        o_reg_rsp.data <= mode_b;
      end else if (i_reg_req.addr == tp_pkg::ADDR_MODE_C) begin
        o_reg_rsp.data <= mode_c;
      end else if (i_reg_req.addr == tp_pkg::ADDR_MODE_D) begin
        o_reg_rsp.data <= mode_d;
      end else if (i_reg_req.addr == tp_pkg::ADDR_PHASE) begin
        o_reg_rsp.data <= phase;
      end else if (i_reg_req.addr == tp_pkg::ADDR_DEVID) begin
        o_reg_rsp.data <= devid;
      end else if (i_reg_req.addr >= tp_pkg::ADDR_USER_BASE &&
                   i_reg_req.addr < tp_pkg::ADDR_STATUS) begin
        o_reg_rsp.data <=
          user_pat[3'(i_reg_req.addr - tp_pkg::ADDR_USER_BASE)];
      end else if (i_reg_req.addr == tp_pkg::ADDR_STATUS) begin
        o_reg_rsp.data <= '0;
        o_reg_rsp.data[tp_pkg::ST_DONE]  <=
          (user_state == tp_pkg::USER_DONE);
        o_reg_rsp.data[tp_pkg::ST_EMPTY] <= !fifo_valid;
        o_reg_rsp.data[tp_pkg::ST_FULL]  <= !fifo_full_n;
      end else begin
        o_reg_rsp.data <= 8'h00;
      end
    end
  end

  // simple transport patterns advance one step per sent word
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      checker_ph <= 1'b0;
      toggle_ph  <= 1'b0;
      ramp       <= '0;
    end else if (tp_restart) begin
      checker_ph <= 1'b0;
      toggle_ph  <= 1'b0;
      ramp       <= '0;
    end else if (take) begin
      checker_ph <= !checker_ph; // RQ2
      toggle_ph  <= !toggle_ph; // RQ3
      ramp       <= ramp + 1'b1; // RQ7
    end
  end

  // user pattern sequencing
  always_comb begin
    next_user_state = user_state;
    case (user_state)
      tp_pkg::USER_IDLE: begin
        if (tp_sel == tp_pkg::TP_USER_ONE) next_user_state = tp_pkg::USER_RUN;
      end
      tp_pkg::USER_RUN: begin
        if (take && user_idx == ($bits(user_idx))'(USER_WORDS - 1))
          next_user_state = tp_pkg::USER_DONE;
      end
      default: begin
        next_user_state = tp_pkg::USER_DONE;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      user_state <= tp_pkg::USER_IDLE;
    end else if (tp_restart) begin
      user_state <= tp_pkg::USER_IDLE;
    end else if (tp_sel == tp_pkg::TP_USER_ONE) begin
      user_state <= next_user_state; // RQ8
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      user_idx <= '0;
    end else if (tp_restart) begin
      user_idx <= '0;
    end else if (take) begin
      if (user_idx == ($bits(user_idx))'(USER_WORDS - 1)) begin
        user_idx <= '0; // RQ8
      end else begin
        user_idx <= user_idx + 1'b1;
      end
    end
  end

  // link sequence position in octets
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      seq_idx <= '0;
    end else if (lt_restart) begin
      seq_idx <= '0;
    end else if (take) begin
      if (seq_idx >= ($bits(seq_idx))'(tp_pkg::SEQ_LEN - OCTETS)) begin
        seq_idx <= '0; // RQ11
      end else begin
        seq_idx <= seq_idx + ($bits(seq_idx))'(OCTETS);
      end
    end
  end

  // transport level word
  always_comb begin
    case (tp_sel)
      tp_pkg::TP_OFF:      tp_word = fifo_data; // RQ1
      tp_pkg::TP_CHECKER:  tp_word = checker_ph ? // RQ2
                             rep_octet(tp_pkg::CHECK_B) :
                             rep_octet(tp_pkg::CHECK_A);
      tp_pkg::TP_TOGGLE:   tp_word = toggle_ph ? '0 : '1; // RQ3
      tp_pkg::TP_PN31,
      tp_pkg::TP_PN23:     tp_word = pn_word; // RQ4
      tp_pkg::TP_PN15:     tp_word = pn_word; // RQ5
      tp_pkg::TP_PN9,
      tp_pkg::TP_PN7:      tp_word = pn_word; // RQ6
      tp_pkg::TP_RAMP:     tp_word = ramp; // RQ7
      tp_pkg::TP_USER_REP: tp_word = user_word(int'(user_idx)); // RQ8
      tp_pkg::TP_USER_ONE: tp_word = // RQ8
                             (next_user_state == tp_pkg::USER_RUN ||
                              user_state == tp_pkg::USER_RUN) ?
                             user_word(int'(user_idx)) : '0;
      default:             tp_word = fifo_data;
    endcase
  end

  // link level override
  always_comb begin
    case (lt_sel)
      tp_pkg::LT_OFF:    next_link_data = tp_word; // RQ9
      tp_pkg::LT_D21_5:  next_link_data = rep_octet(tp_pkg::D21_5); // RQ10
      tp_pkg::LT_RPAT,
      tp_pkg::LT_JSPAT,
      tp_pkg::LT_JTSPAT: next_link_data = // RQ11
                           seq_word(lt_sel, int'(seq_idx));
      default:           next_link_data = tp_word;
    endcase
  end

  // output stage
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_link_valid <= 1'b0;
      o_link_data  <= '0;
    end else if (take) begin
      o_link_valid <= 1'b1;
      o_link_data  <= next_link_data;
    end else if (i_link_ready) begin
      o_link_valid <= 1'b0;
    end
  end

endmodule

/* File: dv/jesd_link_test_pattern_ctrl_sva.sv */
// port assertions for the test pattern controller
`timescale 1ns/100ps
module jesd_link_test_pattern_ctrl_sva #(
  parameter int W = 16
) (
  input wire logic             i_sys_clk,
  input wire logic             i_resetn,
  input wire tp_pkg::reg_req_t i_reg_req,
  input wire tp_pkg::reg_rsp_t o_reg_rsp,
  input wire logic             i_smp_valid,
  input wire logic [W-1:0]     i_smp_data,
  input wire logic             o_smp_ready,
  input wire logic             o_link_valid,
  input wire logic [W-1:0]     o_link_data,
  input wire logic             i_link_ready
);
  logic [3:0]   tp;
  logic [2:0]   lt;
  logic [1:0]   qcnt;
  logic         r_v;
  logic         r_rdy;
  logic         prev_ok;
  logic [W-1:0] prev_word;
  logic         wr_c;
  logic         wr_d;
  logic         fresh;
  logic         qt;
  logic         tq;
  assign wr_c = i_reg_req.wr && i_reg_req.addr == tp_pkg::ADDR_MODE_C;
  assign wr_d = i_reg_req.wr && i_reg_req.addr == tp_pkg::ADDR_MODE_D;
  assign fresh = o_link_valid && (!r_v || r_rdy);
  assign qt = qcnt == 2'h3;
  assign tq = qt && lt == tp_pkg::LT_OFF;
  // mode shadow, cycles since a mode write
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      tp   <= 4'h0;
      lt   <= 3'h0;
      qcnt <= 2'h0;
    end else begin
      if (wr_c)
        tp <= i_reg_req.wdata[3:0];
      if (wr_d)
        lt <= i_reg_req.wdata[2:0];
      if (wr_c || wr_d)
        qcnt <= 2'h0;
      else if (!qt)
        qcnt <= qcnt + 2'h1;
    end
  end
  // previous word sent under a settled mode
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      r_v       <= 1'b0;
      r_rdy     <= 1'b0;
      prev_ok   <= 1'b0;
      prev_word <= '0;
    end else begin
      r_v   <= o_link_valid;
      r_rdy <= i_link_ready;
      if (wr_c || wr_d)
        prev_ok <= 1'b0;
      else if (fresh) begin
        prev_ok   <= qt;
        prev_word <= o_link_data;
      end
    end
  end
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);
  sequence s_idle;
    !i_smp_valid && !o_link_valid;
  endsequence
  sequence s_push;
    i_smp_valid && o_smp_ready;
  endsequence
  a_push_latency: assert property (
    s_idle [*3] ##1 s_push |=> !o_link_valid ##1 o_link_valid)
    else $error("sample word late on link");
  a_read_answers: assert property (
    i_reg_req.rd |=> o_reg_rsp.valid)
    else $error("read without answer");
  a_stall_holds: assert property (
    o_link_valid && !i_link_ready |=> o_link_valid && $stable(o_link_data))
    else $error("link word changed while stalled");
  a_checker_set: assert property (
    fresh && tq && tp == tp_pkg::TP_CHECKER |->
      o_link_data == {2{tp_pkg::CHECK_A}} ||
      o_link_data == {2{tp_pkg::CHECK_B}})
    else $error("checkerboard word wrong");
  a_words_alternate: assert property (
    fresh && tq && prev_ok &&
    (tp == tp_pkg::TP_CHECKER || tp == tp_pkg::TP_TOGGLE) |->
      o_link_data == ~prev_word)
    else $error("pattern word did not alternate");
  a_toggle_set: assert property (
    fresh && tq && tp == tp_pkg::TP_TOGGLE |->
      o_link_data == '1 || o_link_data == '0)
    else $error("toggle word wrong");
  a_ramp_step: assert property (
    fresh && tq && prev_ok && tp == tp_pkg::TP_RAMP |->
      o_link_data == prev_word + W'(1))
    else $error("ramp step wrong");
  a_pn_nonzero: assert property (
    fresh && tq && (tp == tp_pkg::TP_PN9 || tp == tp_pkg::TP_PN7) |->
      o_link_data != '0)
    else $error("short pn word all zero");
  a_d21_stream: assert property (
    fresh && qt && lt == tp_pkg::LT_D21_5 |->
      o_link_data == {2{tp_pkg::D21_5}})
    else $error("link test octets wrong");
endmodule
bind jesd_link_test_pattern_ctrl jesd_link_test_pattern_ctrl_sva #(.W(W))
  i_sva (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn),
  .i_reg_req(i_reg_req), .o_reg_rsp(o_reg_rsp),
  .i_smp_valid(i_smp_valid), .i_smp_data(i_smp_data),
  .o_smp_ready(o_smp_ready), .o_link_valid(o_link_valid),
  .o_link_data(o_link_data), .i_link_ready(i_link_ready));

/* File: dv/link_rx_model.sv */
// far-end receiver: prompt, random or stalled acceptance
`timescale 1ns/100ps
module link_rx_model #(
  parameter int W = 16
) (
  input  wire logic         i_sys_clk,
  input  wire logic         i_resetn,
  input  wire logic [1:0]   i_pace,
  input  wire logic         i_valid,
  input  wire logic [W-1:0] i_data,
  output logic              o_ready,
  output logic              o_got,
  output logic [W-1:0]      o_word
);
  int seed = 77780;
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_ready <= 1'b0;
      o_got   <= 1'b0;
      o_word  <= '0;
    end else begin
      o_got <= i_valid && o_ready;
      // word handed on to the reference check
      if (i_valid && o_ready)
        o_word <= i_data;
      o_ready <= i_pace[1] ? 1'b0 : (i_pace[0] ? 1'($random(seed)) : 1'b1);
    end
  end
endmodule

/* File: dv/jesd_link_test_pattern_ctrl_tb.sv */
// self-checking bench for the test pattern controller
`timescale 1ns/100ps
module jesd_link_test_pattern_ctrl_tb;
  localparam int DEPTH = 32;
  logic             sys_clk;
  logic             resetn;
  tp_pkg::reg_req_t req;
  tp_pkg::reg_rsp_t rsp;
  logic             smp_valid;
  logic [15:0]      smp_data;
  logic             smp_ready;
  logic             link_valid;
  logic [15:0]      link_data;
  logic             link_ready;
  logic [1:0]       pace;
  logic             got;
  logic [15:0]      word;
  logic [15:0]      sq[$];
  logic [15:0]      rq[$];
  logic [7:0]       ub[8];
  int               errors;
  int               tests_run;
  int               seed;
  jesd_link_test_pattern_ctrl #(.W(16), .DEPTH(DEPTH))
    i_jesd_link_test_pattern_ctrl (.i_sys_clk(sys_clk), .i_resetn(resetn),
    .i_reg_req(req), .o_reg_rsp(rsp), .i_smp_valid(smp_valid),
    .i_smp_data(smp_data), .o_smp_ready(smp_ready),
    .o_link_valid(link_valid), .o_link_data(link_data),
    .i_link_ready(link_ready));
  link_rx_model #(.W(16)) i_link_rx_model (.i_sys_clk(sys_clk),
    .i_resetn(resetn), .i_pace(pace), .i_valid(link_valid),
    .i_data(link_data), .o_ready(link_ready), .o_got(got), .o_word(word));
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    if (got)
      rq.push_back(word);
  end
  task automatic chk(input string nm, input logic [15:0] seen,
                     input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge sys_clk);
    req <= '0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge sys_clk);
    req <= '0;
    #1;
    chk("register read", {7'h00, rsp.valid, rsp.data}, {8'h01, e});
  endtask
  task automatic push(input int n, input int lim, output int k);
    int t;
    logic [15:0] d;
    k = 0;
    d = 16'($random(seed));
    @(posedge sys_clk);
    for (t = 0; t < lim && k < n; t++) begin
      smp_valid <= 1'b1;
      smp_data  <= d;
      @(negedge sys_clk);
      if (smp_ready === 1'b1) begin
        sq.push_back(d);
        k++;
        d = 16'($random(seed));
      end
      @(posedge sys_clk);
    end
    smp_valid <= 1'b0;
  endtask
  task automatic collect(input int n);
    int t;
    for (t = 0; t < 3000 && rq.size() < n; t++)
      @(posedge sys_clk);
    if (rq.size() < n) begin
      errors++;
      $display("ERROR link words expected %0d seen %0d", n, rq.size());
      give_verdict();
    end
  endtask
  function automatic logic [15:0] exp_word(input logic [3:0] tp,
    input logic [2:0] lt, input int i, input logic [15:0] s,
    inout logic [30:0] st);
    int n;
    int tap;
    int b;
    logic [15:0] w;
    case (lt)
      tp_pkg::LT_D21_5: return {2{tp_pkg::D21_5}};
      tp_pkg::LT_RPAT: return {tp_pkg::RPAT_SEQ[(2*i)%12],
                               tp_pkg::RPAT_SEQ[(2*i+1)%12]};
      tp_pkg::LT_JSPAT: return {tp_pkg::JSPAT_SEQ[(2*i)%12],
                                tp_pkg::JSPAT_SEQ[(2*i+1)%12]};
      tp_pkg::LT_JTSPAT: return {tp_pkg::JTSPAT_SEQ[(2*i)%12],
                                 tp_pkg::JTSPAT_SEQ[(2*i+1)%12]};
      default: n = 0;
    endcase
    case (tp)
      tp_pkg::TP_CHECKER: return i % 2 ? 16'h5555 : 16'haaaa;
      tp_pkg::TP_TOGGLE: return i % 2 ? 16'h0000 : 16'hffff;
      tp_pkg::TP_RAMP: return 16'(i);
      tp_pkg::TP_USER_REP: return {ub[(2*i)%8], ub[(2*i+1)%8]};
      tp_pkg::TP_USER_ONE:
        return i < 4 ? {ub[(2*i)%8], ub[(2*i+1)%8]} : 16'h0000;
      tp_pkg::TP_PN31: begin n = 31; tap = 28; end
      tp_pkg::TP_PN23: begin n = 23; tap = 18; end
      tp_pkg::TP_PN15: begin n = 15; tap = 14; end
      tp_pkg::TP_PN9: begin n = 9; tap = 5; end
      tp_pkg::TP_PN7: begin n = 7; tap = 6; end
      default: return s;
    endcase
    for (b = 0; b < 16; b++) begin
      st = {st[29:0], st[n-1] ^ st[tap-1]};
      w = {w[14:0], st[0]};
    end
    return w;
  endfunction
  task automatic run(input logic [3:0] tp, input logic [2:0] lt,
                     input logic [1:0] pc);
    int k;
    int i;
    logic [30:0] st;
    pace <= pc;
    wr(tp_pkg::ADDR_MODE_D, {5'h00, lt});
    wr(tp_pkg::ADDR_MODE_C, {4'h0, tp});
    sq.delete();
    rq.delete();
    push(20, 200, k);
    chk("sample count", 16'(k), 16'd20);
    collect(k);
    st = '1;
    for (i = 0; i < k; i++)
      chk("link word", rq[i], exp_word(tp, lt, i, sq[i], st));
    $display("test pattern %h link %h done", tp, lt);
  endtask
  logic [11:0] ra[5] = '{tp_pkg::ADDR_MODE_B, tp_pkg::ADDR_MODE_C,
    tp_pkg::ADDR_MODE_D, tp_pkg::ADDR_PHASE, tp_pkg::ADDR_DEVID};
  logic [7:0]  rm[5] = '{tp_pkg::MASK_MODE_B, tp_pkg::MASK_MODE_C,
    tp_pkg::MASK_MODE_D, tp_pkg::MASK_PHASE, 8'hff};
  logic [3:0]  tps[12] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6,
    4'h7, 4'h8, 4'ha, 4'he, 4'hf};
  logic [2:0]  lts[5] = '{3'h1, 3'h4, 3'h5, 3'h6, 3'h7};
  initial begin
    int i;
    int k;
    logic [7:0] r;
    resetn = 1'b0;
    req = '0;
    smp_valid = 1'b0;
    smp_data = 16'h0000;
    pace = 2'h0;
    errors = 0;
    tests_run = 0;
    seed = 77780;
    repeat (5) @(posedge sys_clk);
    resetn <= 1'b1;
    for (i = 0; i < 5; i++)
      rd(ra[i], 8'h00);
    rd(12'h123, 8'h00);
    for (i = 0; i < 5; i++) begin
      r = 8'($random(seed));
      wr(ra[i], r);
      rd(ra[i], r & rm[i]);
    end
    wr(12'h123, 8'hff);
    rd(12'h123, 8'h00);
    $display("test registers done");
    for (i = 0; i < 8; i++) begin
      ub[i] = 8'($random(seed));
      wr(tp_pkg::ADDR_USER_BASE + 12'(i), ub[i]);
    end
    foreach (tps[j])
      run(tps[j], tp_pkg::LT_OFF, 2'(j % 2));
    foreach (lts[j])
      run(4'($random(seed)), lts[j], 2'(j % 2));
    wr(tp_pkg::ADDR_MODE_D, 8'h00);
    wr(tp_pkg::ADDR_MODE_C, 8'h00);
    sq.delete();
    rq.delete();
    pace <= 2'h2;
    push(64, 80, k);
    chk("fifo fill", 16'(k), 16'(DEPTH + 1));
    rd(tp_pkg::ADDR_STATUS, 8'h01 << tp_pkg::ST_FULL);
    pace <= 2'h1;
    collect(k);
    for (i = 0; i < k; i++)
      chk("fifo drain", rq[i], sq[i]);
    rd(tp_pkg::ADDR_STATUS, 8'h01 << tp_pkg::ST_EMPTY);
    $display("test fifo fill done");
    give_verdict();
  end
endmodule
